//--- rtl/adc_capture_defs.svh
`ifndef ADC_CAPTURE_DEFS_SVH
`define ADC_CAPTURE_DEFS_SVH

// ============================================================
// widths
`define RESULT_W 12
`define AIN_W 16
`define CALC_W 18
`define COUNT_W 16

// ============================================================
// codes and limits, input in half-code units
`define CODE_MAX 12'hFFF
`define CODE_MIN 12'h000
`define BIPOLAR_SHIFT 18'sh01000
`define FS_HALF 18'sh01FFF
`define UNDER_HALF 18'sh3FFFF
`define ROUND_HALF 18'sh00001
`define CODE_MAX_WIDE 18'sh00FFF
`define OFFSET_2048 13'h0800

// ============================================================
// timing counts in clk cycles, buffer depth in entries
`define CONV_CYCLES_DEF 16
`define SAMPLE_DIV_DEF 64
`define TRIG_HIGH_DEF 4
`define FIFO_DEPTH_DEF 16

`endif

//--- rtl/adc_capture_pkg.sv
package adc_capture_pkg;

    // ============================================================
    // range decode result
    typedef enum logic [1:0] {
        IN_RANGE,
        UNDERRANGE,
        OVERRANGE
    } range_e;

    // ============================================================
    // converter sequencer
    typedef enum logic [1:0] {
        TRACK,
        HOLD,
        CONVERT,
        PUBLISH
    } conv_state_e;

endpackage : adc_capture_pkg

//--- rtl/adc_link_if.sv
`timescale 1ns/1ps
`include "adc_capture_defs.svh"
interface adc_link_if;
    logic conversion_trigger;
    logic [`RESULT_W-1:0] result;
    logic result_msb_n;
    logic range_exceeded_flag;
    logic result_valid_strobe;

    modport device (
        input conversion_trigger,
        output result,
        output result_msb_n,
        output range_exceeded_flag,
        output result_valid_strobe
    );

    modport host (
        output conversion_trigger,
        input result,
        input result_msb_n,
        input range_exceeded_flag,
        input result_valid_strobe
    );
endinterface : adc_link_if

//--- rtl/adc_converter_end.sv
`timescale 1ns/1ps
`include "adc_capture_defs.svh"

module adc_converter_end #(
    parameter int CONV_CYCLES = `CONV_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    adc_link_if.device link,
    input wire logic signed [`AIN_W-1:0] ain_half_lsb,
    input wire logic bipolar_span,
    output logic sha_tracking,
    output logic busy,
    output logic trigger_ignored,
    output logic [`COUNT_W-1:0] conversion_count
);

    // ============================================================
    // pin synchronisers
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic signed [`AIN_W-1:0] ain_meta;
    logic signed [`AIN_W-1:0] ain_sync;
    logic span_meta;
    logic span_sync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= link.conversion_trigger;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ain_meta <= '0;
            ain_sync <= '0;
            span_meta <= 1'b0;
            span_sync <= 1'b0;
        end else begin
            ain_meta <= ain_half_lsb;
            ain_sync <= ain_meta;
            span_meta <= bipolar_span;
            span_sync <= span_meta;
        end
    end

    wire trig_rise = trig_sync & ~trig_prev;

    // ============================================================
    // held sample and its span
    logic signed [`AIN_W-1:0] held;
    logic held_bipolar;

    // ============================================================
    // quantiser: binary code from held sample, offset binary in bipolar span
    wire signed [`CALC_W-1:0] held_wide = {{(`CALC_W-`AIN_W){held[`AIN_W-1]}}, held};
    wire signed [`CALC_W-1:0] span_shift = held_bipolar ? `BIPOLAR_SHIFT : '0;
    wire signed [`CALC_W-1:0] level = held_wide + span_shift;
    wire signed [`CALC_W-1:0] rounded = (level + `ROUND_HALF) >>> 1;

    // beyond the outer code centres by half a step
    wire above_span = level > `FS_HALF;
    wire below_span = level < $signed(`UNDER_HALF);
    wire out_of_span = above_span | below_span;

    wire clamp_high = rounded > `CODE_MAX_WIDE;
    wire clamp_low = rounded[`CALC_W-1];

    // saturation at both ends; bipolar code is offset binary here
    wire [`RESULT_W-1:0] code = clamp_high ? `CODE_MAX :
        clamp_low ? `CODE_MIN :
        rounded[`RESULT_W-1:0];

    // ============================================================
    // sequencer
    adc_capture_pkg::conv_state_e state;
    adc_capture_pkg::conv_state_e next_state;
    logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt;

    wire conv_last = conv_cnt == '0;
    wire in_track = state == adc_capture_pkg::TRACK;
    wire take_trigger = in_track & trig_rise;

    always_comb begin
        next_state = state;
        unique case (state)
            adc_capture_pkg::TRACK: begin
                if (trig_rise) begin
                    next_state = adc_capture_pkg::HOLD;
                end
            end
            adc_capture_pkg::HOLD: begin
                next_state = adc_capture_pkg::CONVERT;
            end
            adc_capture_pkg::CONVERT: begin
                if (conv_last) begin
                    next_state = adc_capture_pkg::PUBLISH;
                end
            end
            adc_capture_pkg::PUBLISH: begin
                next_state = adc_capture_pkg::TRACK;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= adc_capture_pkg::TRACK;
        end else begin
            state <= next_state;
        end
    end

    // ============================================================
    // sample hold: hold on trigger, re-acquire as strobe falls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= '0;
            held_bipolar <= 1'b0;
        end else if (take_trigger) begin
            held <= ain_sync;
            held_bipolar <= span_sync;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sha_tracking <= 1'b1;
        end else if (take_trigger) begin
            sha_tracking <= 1'b0;
        end else if (state == adc_capture_pkg::HOLD) begin
            sha_tracking <= 1'b1;
        end
    end

    // ============================================================
    // conversion timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_cnt <= '0;
        end else if (state == adc_capture_pkg::HOLD) begin
            conv_cnt <= ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
        end else if (state == adc_capture_pkg::CONVERT && !conv_last) begin
            conv_cnt <= conv_cnt - 1'b1;
        end
    end

    // ============================================================
    // strobe: falls at hold, rises one cycle after new data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.result_valid_strobe <= 1'b1;
        end else if (state == adc_capture_pkg::HOLD) begin
            link.result_valid_strobe <= 1'b0;
        end else if (state == adc_capture_pkg::PUBLISH) begin
            link.result_valid_strobe <= 1'b1;
        end
    end

    // result and flag change only at the end of a conversion
    wire publish_now = state == adc_capture_pkg::CONVERT && conv_last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.result <= `CODE_MIN;
            link.result_msb_n <= 1'b1;
            link.range_exceeded_flag <= 1'b0;
        end else if (publish_now) begin
            link.result <= code;
            link.result_msb_n <= ~code[`RESULT_W-1];
            link.range_exceeded_flag <= out_of_span;
        end
    end

    // ============================================================
    // status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (take_trigger) begin
            busy <= 1'b1;
        end else if (state == adc_capture_pkg::PUBLISH) begin
            busy <= 1'b0;
        end
    end

    // a trigger edge while converting is dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trigger_ignored <= 1'b0;
        end else begin
            trigger_ignored <= trig_rise & ~in_track;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conversion_count <= '0;
        end else if (state == adc_capture_pkg::PUBLISH) begin
            conversion_count <= conversion_count + 1'b1;
        end
    end

endmodule : adc_converter_end

//--- rtl/adc_capture_end.sv
`timescale 1ns/1ps
`include "adc_capture_defs.svh"

// ============================================================
// result buffer
module result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = `FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire do_push = in_valid & in_ready;
    wire do_pop = out_valid & out_ready;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= do_push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
            rd_ptr <= do_pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : result_fifo

// ============================================================
// capture, decode and processor read side
module adc_capture_end #(
    parameter int SAMPLE_DIV = `SAMPLE_DIV_DEF,
    parameter int TRIG_HIGH = `TRIG_HIGH_DEF,
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rst,
    adc_link_if.host link,
    input wire logic sampling_enable,
    input wire logic capture_previous,
    input wire logic twos_complement,
    input wire logic remove_offset,
    input wire logic read_select,
    output logic host_interrupt_line_a,
    output logic read_valid,
    output logic [`RESULT_W-1:0] read_data,
    output logic signed [`RESULT_W:0] read_signed,
    output adc_capture_pkg::range_e read_range,
    output logic capture_dropped
);
    localparam int WORD_W = `RESULT_W + 1;
    localparam int DW = $clog2(SAMPLE_DIV);

    // ============================================================
    // trigger divider, stalled while the buffer is full
    logic [DW-1:0] div_cnt;
    logic fifo_in_ready;
    logic fifo_out_valid;

    wire period_end = div_cnt == '0;
    wire high_end = div_cnt == DW'(SAMPLE_DIV - TRIG_HIGH);
    wire start_trig = period_end & sampling_enable & fifo_in_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (period_end) begin
            div_cnt <= start_trig ? DW'(SAMPLE_DIV - 1) : '0;
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.conversion_trigger <= 1'b0;
        end else if (start_trig) begin
            link.conversion_trigger <= 1'b1;
        end else if (high_end) begin
            link.conversion_trigger <= 1'b0;
        end
    end

    // interrupt on trigger fall once a result waits
    wire trig_fall = link.conversion_trigger & high_end;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_interrupt_line_a <= 1'b0;
        end else begin
            host_interrupt_line_a <= trig_fall & fifo_out_valid;
        end
    end

    // ============================================================
    // link synchronisers, strobe idles high
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic [WORD_W:0] data_meta;
    logic [WORD_W:0] data_sync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_meta <= 1'b1;
            strobe_sync <= 1'b1;
            strobe_prev <= 1'b1;
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            strobe_meta <= link.result_valid_strobe;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
            data_meta <= {link.result_msb_n, link.result, link.range_exceeded_flag};
            data_sync <= data_meta;
        end
    end

    wire strobe_rise = strobe_sync & ~strobe_prev;
    wire strobe_fall = ~strobe_sync & strobe_prev;
    wire capture = capture_previous ? strobe_fall : strobe_rise;

    // top bit chosen as true or complemented, as by wiring
    wire top_bit = twos_complement ? data_sync[WORD_W] : data_sync[WORD_W-1];
    wire [WORD_W-1:0] word_in = {top_bit, data_sync[WORD_W-2:0]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_dropped <= 1'b0;
        end else begin
            capture_dropped <= capture & ~fifo_in_ready;
        end
    end

    // ============================================================
    // buffer
    logic [WORD_W-1:0] word_out;

    result_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_result_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(capture),
        .in_ready(fifo_in_ready),
        .in_data(word_in),
        .out_valid(fifo_out_valid),
        .out_ready(read_select),
        .out_data(word_out)
    );

    // ============================================================
    // decode of the word being read
    wire [`RESULT_W-1:0] out_code = word_out[WORD_W-1:1];
    wire out_flag = word_out[0];
    wire out_top = out_code[`RESULT_W-1];

    wire adc_capture_pkg::range_e range_now = !out_flag ? adc_capture_pkg::IN_RANGE :
        out_top ? adc_capture_pkg::OVERRANGE :
        adc_capture_pkg::UNDERRANGE;

    wire signed [`RESULT_W:0] signed_now = remove_offset ?
        $signed({1'b0, out_code} - `OFFSET_2048) :
        $signed({out_top, out_code});

    wire read_take = read_select & fifo_out_valid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_valid <= 1'b0;
            read_data <= '0;
            read_signed <= '0;
            read_range <= adc_capture_pkg::IN_RANGE;
        end else begin
            read_valid <= read_take;
            if (read_take) begin
                read_data <= out_code;
                read_signed <= signed_now;
                read_range <= range_now;
            end
        end
    end

endmodule : adc_capture_end

//--- testbench/adc_link_asserts.sv
`timescale 1ns/1ps
`include "adc_capture_defs.svh"
// ============================================================
// link checker
module adc_link_asserts #(
    parameter int CONV_CYCLES = `CONV_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic conversion_trigger,
    input wire logic [`RESULT_W-1:0] result,
    input wire logic result_msb_n,
    input wire logic range_exceeded_flag,
    input wire logic result_valid_strobe
);
    logic [7:0] low_len;
    logic [7:0] next_low_len;

    // cycles the strobe has been low
    assign next_low_len = result_valid_strobe ? 8'h00 : low_len + 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_len <= 8'h00;
        end else begin
            low_len <= next_low_len;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ============================================================
    // assertions
    a_strobe_low_span: assert property (
        $rose(result_valid_strobe) |-> low_len == CONV_CYCLES + 1)
        else $error("strobe low span wrong");
    a_msb_pair: assert property (result_msb_n != result[11])
        else $error("complement top bit mismatch");
    a_over_code: assert property (
        range_exceeded_flag && result[11] |-> result == `CODE_MAX)
        else $error("overrange code not saturated");
    a_under_code: assert property (
        range_exceeded_flag && !result[11] |-> result == `CODE_MIN)
        else $error("underrange code not saturated");
    a_update_at_end: assert property (
        $changed({result, range_exceeded_flag}) |-> !result_valid_strobe ##1 result_valid_strobe)
        else $error("data changed outside conversion end");
    a_trig_starts: assert property (
        $rose(conversion_trigger) && result_valid_strobe |-> ##[2:8] $fell(result_valid_strobe))
        else $error("trigger did not start conversion");
    a_fall_cause: assert property (
        $fell(result_valid_strobe) |-> $past(conversion_trigger, 2))
        else $error("conversion without trigger");
    a_trig_width: assert property (
        $rose(conversion_trigger) |-> conversion_trigger[*4] ##1 !conversion_trigger)
        else $error("trigger pulse width wrong");

    c_strobe_rise: cover property ($rose(result_valid_strobe));
    c_flag_rise: cover property ($rose(range_exceeded_flag));
    c_flag_fall: cover property ($fell(range_exceeded_flag));
endmodule : adc_link_asserts

//--- testbench/adc_result_capture_range_decode_bench.sv
`timescale 1ns/1ps
`include "adc_capture_defs.svh"
module adc_result_capture_range_decode_bench;
    localparam int CONV = 4;
    localparam adc_capture_pkg::range_e rin = adc_capture_pkg::IN_RANGE;
    localparam adc_capture_pkg::range_e rund = adc_capture_pkg::UNDERRANGE;
    localparam adc_capture_pkg::range_e rovr = adc_capture_pkg::OVERRANGE;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic signed [`AIN_W-1:0] ain_half_lsb = '0;
    logic bipolar_span = 1'b0;
    logic sampling_enable = 1'b0;
    logic capture_previous = 1'b0;
    logic twos_complement = 1'b0;
    logic remove_offset = 1'b0;
    logic read_select = 1'b0;
    logic sha_tracking, busy, trigger_ignored, host_interrupt_line_a, read_valid, capture_dropped;
    logic [`COUNT_W-1:0] conversion_count;
    logic [`RESULT_W-1:0] read_data;
    logic signed [`RESULT_W:0] read_signed;
    adc_capture_pkg::range_e read_range;
    int failures = 0;
    int num_checks = 0;
    int irq_seen = 0;
    int drops = 0;
    int conversions = 0;

    always #10 clk = ~clk;

    adc_link_if link ();

    adc_converter_end #(.CONV_CYCLES(CONV)) u_adc_converter_end (
        .clk(clk), .rst(rst), .link(link), .ain_half_lsb(ain_half_lsb),
        .bipolar_span(bipolar_span), .sha_tracking(sha_tracking), .busy(busy),
        .trigger_ignored(trigger_ignored), .conversion_count(conversion_count));

    adc_capture_end #(.SAMPLE_DIV(16), .TRIG_HIGH(4), .FIFO_DEPTH(16)) u_adc_capture_end (
        .clk(clk), .rst(rst), .link(link), .sampling_enable(sampling_enable),
        .capture_previous(capture_previous), .twos_complement(twos_complement),
        .remove_offset(remove_offset), .read_select(read_select),
        .host_interrupt_line_a(host_interrupt_line_a), .read_valid(read_valid),
        .read_data(read_data), .read_signed(read_signed), .read_range(read_range),
        .capture_dropped(capture_dropped));

    adc_link_asserts #(.CONV_CYCLES(CONV)) u_adc_link_asserts (
        .clk(clk), .rst(rst), .conversion_trigger(link.conversion_trigger),
        .result(link.result), .result_msb_n(link.result_msb_n),
        .range_exceeded_flag(link.range_exceeded_flag),
        .result_valid_strobe(link.result_valid_strobe));

    always @(negedge clk) begin
        if (host_interrupt_line_a === 1'b1) irq_seen++;
        if (capture_dropped === 1'b1 || trigger_ignored === 1'b1) drops++;
    end

    // ============================================================
    // shared tasks
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_range(input adc_capture_pkg::range_e got,
                             input adc_capture_pkg::range_e exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_range

    task automatic do_read(output logic got);
        got = 1'b0;
        @(negedge clk);
        read_select = 1'b1;
        @(negedge clk);
        read_select = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (read_valid === 1'b1) got = 1'b1;
            if (!got) @(negedge clk);
        end
    endtask : do_read

    task automatic sample_once();
        int n;
        n = 0;
        @(negedge clk);
        sampling_enable = 1'b1;
        while (link.conversion_trigger !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        sampling_enable = 1'b0;
        while (link.result_valid_strobe !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        while (link.result_valid_strobe !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (6) @(negedge clk);
        conversions++;
        chk_val(16'(n < 100), 16'h1);
        chk_val(sha_tracking, 16'h1);
        chk_val(busy, 16'h0);
    endtask : sample_once

    task automatic run_case(input logic signed [15:0] ain, input logic bip, input logic twos,
                            input logic [15:0] exp_data, input logic [15:0] exp_signed,
                            input adc_capture_pkg::range_e exp_rng);
        logic got;
        ain_half_lsb = ain;
        bipolar_span = bip;
        twos_complement = twos;
        remove_offset = !twos;
        sample_once();
        do_read(got);
        chk_val(got, 16'h1);
        chk_val(read_data, exp_data);
        chk_val({3'h0, read_signed}, exp_signed);
        chk_range(read_range, exp_rng);
        do_read(got);
        chk_val(got, 16'h0);
    endtask : run_case

    // ============================================================
    // scenarios
    task automatic test_unipolar();
        run_case(16'sd0, 1'b0, 1'b0, 16'h000, 16'h1800, rin);
        run_case(16'sd1, 1'b0, 1'b0, 16'h001, 16'h1801, rin);
        run_case(-16'sd1, 1'b0, 1'b0, 16'h000, 16'h1800, rin);
        run_case(16'sd8192, 1'b0, 1'b0, 16'hFFF, 16'h07FF, rovr);
        run_case(16'sd8191, 1'b0, 1'b0, 16'hFFF, 16'h07FF, rin);
        run_case(-16'sd2, 1'b0, 1'b0, 16'h000, 16'h1800, rund);
    endtask : test_unipolar

    task automatic test_bipolar();
        run_case(16'sd0, 1'b1, 1'b0, 16'h800, 16'h0000, rin);
        run_case(-16'sd4096, 1'b1, 1'b1, 16'h800, 16'h1800, rin);
        run_case(16'sd4095, 1'b1, 1'b1, 16'h7FF, 16'h07FF, rin);
        run_case(16'sd4096, 1'b1, 1'b0, 16'hFFF, 16'h07FF, rovr);
        run_case(-16'sd4098, 1'b1, 1'b0, 16'h000, 16'h1800, rund);
    endtask : test_bipolar

    task automatic test_previous();
        logic got;
        capture_previous = 1'b1;
        ain_half_lsb = 16'sd200;
        bipolar_span = 1'b0;
        sample_once();
        do_read(got);
        chk_val(read_data, 16'h000);
        chk_range(read_range, rund);
        sample_once();
        do_read(got);
        chk_val(read_data, 16'h064);
        chk_range(read_range, rin);
        capture_previous = 1'b0;
    endtask : test_previous

    task automatic test_fill();
        logic got;
        int n;
        ain_half_lsb = 16'sd10;
        sampling_enable = 1'b1;
        repeat (16 * 22) @(negedge clk);
        sampling_enable = 1'b0;
        repeat (40) @(negedge clk);
        n = 0;
        got = 1'b1;
        while (got && n < 20) begin
            do_read(got);
            if (got) n++;
            if (got) chk_val(read_data, 16'h005);
        end
        conversions += 16;
        chk_val(16'(n), 16'd16);
        chk_val(16'(drops), 16'h0);
        chk_val(conversion_count, 16'(conversions));
        chk_val(16'(irq_seen > 0), 16'h1);
    endtask : test_fill

    task automatic give_verdict();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_val(link.result_valid_strobe, 16'h1);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        test_unipolar();
        test_bipolar();
        test_previous();
        test_fill();
        give_verdict();
    end
endmodule : adc_result_capture_range_decode_bench
